// ---- hdl/bdsup_top.sv ----
// Supervisor for a sensorless 120-degree conducting motor drive.
// Function
// - Duty equals command voltage over bus voltage.
// - Chop upper arms; complementary option at build.
// - System mode: stopped, driving, abnormal.
// - Run mode changes only on events.
// - Operator stop/drive/reset; faults raise error event.
// - Zero crossings give position every 60 degrees.
// - Align, open loop, closed after three crossings.
// - Position detection replaces alignment before open loop.
// - External overcurrent stop input halts output.
// - Shunt comparator overcurrent halts output.
// - Millisecond check: bus above 28 V halts.
// - Millisecond check: bus below 15 V halts.
// - Millisecond check: speed above 3975 rpm halts.
// - No zero crossing within timeout halts output.
// - Unexpected voltage pattern halts output.
// - Rise counter overflow during detection halts.
// - Samples scaled to per-unit; duty unscaled.
// - Bases: rated voltage, maximum electrical frequency.
`timescale 1ns/100ps
module bdsup_top #(
	parameter int MS_CYCLES = bdsup_pkg::MONITOR_CYCLES, // Cycles per monitoring tick.
	parameter int PWM_PERIOD = 2000, // Carrier period in clock cycles.
	parameter int ALIGN_MS = 200, // Draw-in hold time.
	parameter int OL_STEP_MS = 20, // Forced commutation step in open loop.
	parameter int TIMEOUT_MS = 100, // Longest wait for a zero crossing.
	parameter bit COMPLEMENTARY = 1'b0 // Lower arm of chopped phase runs complementary.
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic stop_evt_i,
	input wire logic drive_evt_i,
	input wire logic reset_evt_i,
	input wire logic ipd_en_i,
	input wire logic ipd_done_i,
	input wire logic [bdsup_pkg::PAT_W-1:0] ipd_pat_i,
	input wire logic rise_cnt_ovf_i,
	input wire logic hw_estop_n_i,
	input wire logic shunt_oc_i,
	input wire logic zero_cross_i,
	input wire logic [bdsup_pkg::PAT_W-1:0] pattern_pin_i,
	input wire logic [bdsup_pkg::ADC_W-1:0] vbus_raw_i,
	input wire logic [bdsup_pkg::ADC_W-1:0] vcmd_raw_i,
	input wire logic [bdsup_pkg::PU_W-1:0] speed_rpm_i,
	output bdsup_pkg::bdsup_sys_e sys_mode_o,
	output bdsup_pkg::bdsup_phase_e phase_o,
	output logic [bdsup_pkg::PAT_W-1:0] pattern_o,
	output logic [$clog2(PWM_PERIOD+1)-1:0] duty_o,
	output logic [2:0] gate_hi_o,
	output logic [2:0] gate_lo_o,
	output logic [bdsup_pkg::NUM_FLT-1:0] fault_o,
	output logic err_event_o
);
	import bdsup_pkg::*;
	localparam int DW = $clog2(PWM_PERIOD + 1);
	localparam int MSW = $clog2(MS_CYCLES);

	// Refuse settings that the counters or the divider cannot serve.
	if (MS_CYCLES < 2 || PWM_PERIOD <= DIV_W + 2 || ALIGN_MS < 1 || OL_STEP_MS < 1
			|| TIMEOUT_MS < 1 || TIMEOUT_MS >= 2 ** PH_CNT_W) begin : g_bad_param
		$error("bdsup_top: parameter out of range");
	end

	// Phase drives for a commutation pattern, bit 0 is U, bit 2 is W.
	function automatic logic [2:0] pat_high(input logic [2:0] p);
		case (p)
			3'h0, 3'h1: pat_high = 3'h4;
			3'h2, 3'h3: pat_high = 3'h2;
			3'h4, 3'h5: pat_high = 3'h1;
			default: pat_high = 3'h0;
		endcase
	endfunction

	function automatic logic [2:0] pat_low(input logic [2:0] p);
		case (p)
			3'h0, 3'h5: pat_low = 3'h2;
			3'h1, 3'h2: pat_low = 3'h1;
			3'h3, 3'h4: pat_low = 3'h4;
			default: pat_low = 3'h0;
		endcase
	endfunction

	// Wrap from the sixth pattern back to the first.
	function automatic logic [2:0] pat_next(input logic [2:0] p);
		pat_next = (p == PAT_LAST) ? ALIGN_PAT : p + 3'h1;
	endfunction

	logic [PIN_W-1:0] pin_raw; // Pins gathered for synchronising.
	logic [PIN_W-1:0] pin_s1; // First stage, read only by the second.
	logic [PIN_W-1:0] pin_s2; // Second stage.
	logic [PIN_W-1:0] pin_s3; // Third stage.
	logic [PIN_W-1:0] pin_f; // Accepted level once stages two and three agree.
	logic zc_prev; // Last accepted zero-crossing level.
	logic [MSW-1:0] ms_cnt; // Monitoring tick divider.
	logic [PH_CNT_W-1:0] ph_cnt; // Milliseconds spent in the current step.
	logic [PH_CNT_W-1:0] to_cnt; // Milliseconds since the last zero crossing.
	logic [ZC_CNT_W-1:0] zc_cnt; // Zero crossings seen in open loop.
	logic [DW-1:0] pwm_cnt; // Carrier counter.
	logic [DW-1:0] duty_pend; // Duty waiting for the next carrier period.
	logic [NUM_FLT-1:0] fault_now; // Faults detected this cycle.
	bdsup_sys_e next_sys;
	bdsup_phase_e next_phase;
	logic [PAT_W-1:0] next_pat;
	logic [PH_CNT_W-1:0] next_ph_cnt;
	logic [ZC_CNT_W-1:0] next_zc_cnt;
	logic [2:0] next_hi;
	logic [2:0] next_lo;
	bdsup_div_if div_bus();

	// Pin inputs cross through three flops; a level is taken when two agree.
	assign pin_raw = {pattern_pin_i, zero_cross_i, shunt_oc_i, hw_estop_n_i};
	for (genvar g = 0; g < PIN_W; g++) begin : g_sync
		always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pin_s1[g] <= PIN_RST[g];
				pin_s2[g] <= PIN_RST[g];
				pin_s3[g] <= PIN_RST[g];
				pin_f[g] <= PIN_RST[g];
			end else begin
				pin_s1[g] <= pin_raw[g];
				pin_s2[g] <= pin_s1[g];
				pin_s3[g] <= pin_s2[g];
				if (pin_s2[g] == pin_s3[g]) begin
					pin_f[g] <= pin_s3[g];
				end
			end
		end
	end

	// Decoded pin levels and status.
	wire ext_oc = !pin_f[PIN_ESTOP_N];
	wire shunt_oc = pin_f[PIN_SHUNT];
	wire zc_edge = pin_f[PIN_ZC] && !zc_prev;
	wire [PAT_W-1:0] pat_obs = pin_f[PIN_PAT +: PAT_W];
	wire ms_tick = ms_cnt == MSW'(MS_CYCLES - 1);
	wire is_act = sys_mode_o == SYS_ACTIVE;
	wire is_err = sys_mode_o == SYS_ERROR;
	wire spinning = phase_o == PH_OPEN || phase_o == PH_CLOSED;
	wire err_evt = |fault_now;
	wire pwm_wrap = pwm_cnt == DW'(PWM_PERIOD - 1);
	wire chop = pwm_cnt < duty_o;

	// Per-unit scaling of the samples; a shared base makes m unit-free.
	wire [23:0] vbus_prod = 24'(vbus_raw_i) * 24'(VOLT_GAIN);
	wire [23:0] vcmd_prod = 24'(vcmd_raw_i) * 24'(VOLT_GAIN);
	wire [31:0] spd_prod = 32'(speed_rpm_i) * 32'(SPEED_GAIN);
	wire [PU_W-1:0] vbus_pu = vbus_prod[GAIN_SHIFT +: PU_W];
	wire [PU_W-1:0] vcmd_pu = vcmd_prod[GAIN_SHIFT +: PU_W];
	wire [PU_W-1:0] speed_pu = spd_prod[GAIN_SHIFT +: PU_W];

	// Modulation factor times the period is formed once per carrier period.
	assign div_bus.start = pwm_cnt == '0;
	assign div_bus.dividend = 32'(vcmd_pu) * 32'(PWM_PERIOD);
	assign div_bus.divisor = vbus_pu;
	wire [DW-1:0] duty_clamp = (div_bus.quotient > DIV_W'(PWM_PERIOD))
		? DW'(PWM_PERIOD) : div_bus.quotient[DW-1:0];

	bdsup_divider u_div (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.div(div_bus.slave)
	);

	// Fault detection; the millisecond checks sample only on the tick.
	always_comb begin
		fault_now = '0;
		fault_now[FLT_EXT_OC] = ext_oc;
		fault_now[FLT_SHUNT_OC] = shunt_oc;
		fault_now[FLT_OV] = ms_tick && vbus_pu > PU_W'(OV_PU);
		fault_now[FLT_UV] = ms_tick && is_act && vbus_pu < PU_W'(UV_PU);
		fault_now[FLT_SPEED] = ms_tick && is_act && speed_pu > PU_W'(OVERSPEED_PU);
		fault_now[FLT_TIMEOUT] = ms_tick && is_act && spinning
			&& to_cnt == PH_CNT_W'(TIMEOUT_MS - 1);
		fault_now[FLT_PATTERN] = ms_tick && is_act && phase_o == PH_CLOSED
			&& (pat_obs == PAT_NONE || pat_obs == PAT_ALL);
		fault_now[FLT_RISE_OVF] = rise_cnt_ovf_i && phase_o == PH_IPD;
	end

	// System mode moves only on an event; the error event outranks the rest.
	always_comb begin
		next_sys = sys_mode_o;
		unique case (sys_mode_o)
			SYS_INACTIVE: begin
				if (err_evt) begin
					next_sys = SYS_ERROR;
				end else if (drive_evt_i) begin
					next_sys = SYS_ACTIVE;
				end
			end
			SYS_ACTIVE: begin
				if (err_evt) begin
					next_sys = SYS_ERROR;
				end else if (stop_evt_i) begin
					next_sys = SYS_INACTIVE;
				end
			end
			SYS_ERROR: begin
				// A reset is refused while a fault is still present.
				if (reset_evt_i && !err_evt) begin
					next_sys = SYS_INACTIVE;
				end
			end
			default: next_sys = SYS_INACTIVE;
		endcase
	end

	// Startup sequence and commutation pattern.
	always_comb begin
		next_phase = phase_o;
		next_pat = pattern_o;
		next_ph_cnt = ms_tick ? ph_cnt + PH_CNT_W'(1) : ph_cnt;
		next_zc_cnt = zc_cnt;
		if (next_sys != SYS_ACTIVE) begin
			next_phase = PH_IDLE;
			next_ph_cnt = '0;
			next_zc_cnt = '0;
		end else begin
			unique case (phase_o)
				PH_IDLE: begin
					// Detection replaces the draw-in when it is enabled.
					next_phase = ipd_en_i ? PH_IPD : PH_ALIGN;
					next_pat = ALIGN_PAT;
					next_ph_cnt = '0;
				end
				PH_ALIGN: begin
					if (ms_tick && ph_cnt == PH_CNT_W'(ALIGN_MS - 1)) begin
						next_phase = PH_OPEN;
						next_ph_cnt = '0;
					end
				end
				PH_IPD: begin
					next_ph_cnt = '0;
					if (ipd_done_i) begin
						next_phase = PH_OPEN;
						next_pat = (ipd_pat_i > PAT_LAST) ? ALIGN_PAT : ipd_pat_i;
					end
				end
				PH_OPEN: begin
					if (zc_edge) begin
						next_zc_cnt = zc_cnt + ZC_CNT_W'(1);
						if (zc_cnt == ZC_CNT_W'(ZC_TO_CLOSED - 1)) begin
							next_phase = PH_CLOSED;
						end
					end
					if (ms_tick && ph_cnt == PH_CNT_W'(OL_STEP_MS - 1)) begin
						next_pat = pat_next(pattern_o);
						next_ph_cnt = '0;
					end
				end
				PH_CLOSED: begin
					// Each crossing marks a further 60 electrical degrees.
					next_ph_cnt = '0;
					if (zc_edge) begin
						next_pat = pat_next(pattern_o);
					end
				end
			endcase
		end
	end

	// Gate levels follow the state being entered, so a stop lands on the same
	// edge as the mode change. No dead time is inserted in complementary use;
	// the gate driver must supply it.
	wire drive_on = next_sys == SYS_ACTIVE && (next_phase == PH_ALIGN
		|| next_phase == PH_OPEN || next_phase == PH_CLOSED);
	assign next_hi = (drive_on && chop) ? pat_high(next_pat) : 3'h0;
	assign next_lo = drive_on ? (pat_low(next_pat)
		| ((COMPLEMENTARY && !chop) ? pat_high(next_pat) : 3'h0)) : 3'h0;

	// Mode, phase and gate registers.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sys_mode_o <= SYS_INACTIVE;
			phase_o <= PH_IDLE;
			pattern_o <= ALIGN_PAT;
			gate_hi_o <= 3'h0;
			gate_lo_o <= 3'h0;
		end else begin
			sys_mode_o <= next_sys;
			phase_o <= next_phase;
			pattern_o <= next_pat;
			gate_hi_o <= next_hi;
			gate_lo_o <= next_lo;
		end
	end

	// Counters for the tick, the step timers, the crossings and the carrier.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ms_cnt <= '0;
			ph_cnt <= '0;
			to_cnt <= '0;
			zc_cnt <= '0;
			zc_prev <= 1'b0;
			pwm_cnt <= '0;
		end else begin
			ms_cnt <= ms_tick ? '0 : ms_cnt + MSW'(1);
			ph_cnt <= next_ph_cnt;
			zc_cnt <= next_zc_cnt;
			zc_prev <= pin_f[PIN_ZC];
			pwm_cnt <= pwm_wrap ? '0 : pwm_cnt + DW'(1);
			if (zc_edge || !spinning) begin
				to_cnt <= '0;
			end else if (ms_tick) begin
				to_cnt <= to_cnt + PH_CNT_W'(1);
			end
		end
	end

	// Duty is taken from the divider and applied only at a period boundary so
	// that no carrier period mixes two duties.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			duty_pend <= '0;
			duty_o <= '0;
		end else begin
			if (div_bus.done) begin
				duty_pend <= duty_clamp;
			end
			if (pwm_wrap) begin
				duty_o <= duty_pend;
			end
		end
	end

	// Sticky fault flags; a new fault wins over a reset in the same cycle.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fault_o <= '0;
			err_event_o <= 1'b0;
		end else begin
			fault_o <= (fault_o & ~{NUM_FLT{reset_evt_i && is_err}}) | fault_now;
			err_event_o <= err_evt;
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	chk_gates_idle: assert property (sys_mode_o != SYS_ACTIVE |-> gate_hi_o == 3'h0
		&& gate_lo_o == 3'h0) else $error("gates active outside driving mode");
	chk_arm_overlap: assert property ((gate_hi_o & gate_lo_o) == 3'h0 && !(gate_hi_o != 3'h0
		&& duty_o == '0 && pwm_cnt != '0)) else $error("upper and lower arm overlap");
	chk_three_modes: assert property ($onehot(sys_mode_o))
		else $error("system mode code illegal");
	chk_mode_event: assert property ($changed(sys_mode_o) |-> $past(drive_evt_i)
		|| $past(stop_evt_i) || $past(reset_evt_i) || $past(err_evt))
		else $error("mode changed without an event");
	chk_fault_error: assert property (err_evt |=> sys_mode_o == SYS_ERROR
		&& err_event_o && fault_o != '0) else $error("fault did not raise error");
	chk_error_latch: assert property (is_err && !reset_evt_i |=> is_err)
		else $error("abnormal mode left without reset");
	chk_closed_entry: assert property ($rose(phase_o == PH_CLOSED) |-> $past(phase_o) == PH_OPEN
		&& $past(zc_cnt) == ZC_CNT_W'(ZC_TO_CLOSED - 1)) else $error("early closed loop");
	chk_ipd_skip: assert property (phase_o == PH_IDLE && next_sys == SYS_ACTIVE && ipd_en_i
		|=> phase_o == PH_IPD ##1 phase_o != PH_ALIGN) else $error("alignment not skipped");
	chk_ov_stop: assert property (ms_tick && vbus_pu > PU_W'(OV_PU) |=> fault_o[FLT_OV]
		&& gate_hi_o == 3'h0) else $error("overvoltage did not stop output");
	chk_duty_range: assert property (pwm_wrap |=> duty_o == $past(duty_pend)
		&& duty_o <= DW'(PWM_PERIOD)) else $error("duty out of range");
endmodule

// ---- shared/bdsup_pkg.sv ----
// Shared constants, types and state codes for the drive supervisor.
package bdsup_pkg;
	// Clock period and the protection monitoring period.
	localparam int CLK_PERIOD_NS = 25;
	localparam int NS_PER_MS = 1000000;
	localparam int MONITOR_PERIOD_MS = 1;
	localparam int MONITOR_CYCLES = MONITOR_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
	// Converter scale: the full code stands for 111 V.
	localparam int ADC_W = 10;
	localparam int ADC_MAX = 1023;
	localparam int ADC_FULL_V = 111;
	// Per-unit words are 16 bits with 12 fraction bits.
	localparam int PU_W = 16;
	localparam int PU_ONE = 4096;
	localparam int GAIN_SHIFT = 8;
	localparam int GAIN_ONE = 256;
	// Base values: rated voltage and maximum electrical frequency.
	localparam int RATED_V = 24;
	localparam int MAX_RPM = 4000;
	localparam int POLE_PAIRS = 2;
	localparam int SEC_PER_MIN = 60;
	localparam int MILLI = 1000;
	localparam int BASE_FREQ_MHZ = MAX_RPM * MILLI / SEC_PER_MIN * POLE_PAIRS;
	localparam int VOLT_GAIN = ADC_FULL_V * PU_ONE * GAIN_ONE / (ADC_MAX * RATED_V);
	localparam int SPEED_GAIN =
		PU_ONE * GAIN_ONE / SEC_PER_MIN * POLE_PAIRS * MILLI / BASE_FREQ_MHZ;
	// Protection thresholds; the two current limits are set in the analog front end.
	localparam int EXT_OC_LIMIT_MA = 2000;
	localparam int SHUNT_OC_LIMIT_MA = 1470;
	localparam int OV_LIMIT_V = 28;
	localparam int UV_LIMIT_V = 15;
	localparam int OVERSPEED_RPM = 3975;
	localparam int OV_PU = OV_LIMIT_V * PU_ONE / RATED_V;
	localparam int UV_PU = UV_LIMIT_V * PU_ONE / RATED_V;
	localparam int OVERSPEED_PU = OVERSPEED_RPM * SPEED_GAIN / GAIN_ONE;
	// Startup and commutation.
	localparam int ZC_TO_CLOSED = 3;
	localparam int ZC_CNT_W = 2;
	localparam int PAT_W = 3;
	localparam logic [2:0] PAT_LAST = 3'h5;
	localparam logic [2:0] ALIGN_PAT = 3'h0;
	localparam logic [2:0] PAT_NONE = 3'h0;
	localparam logic [2:0] PAT_ALL = 3'h7;
	localparam int PH_CNT_W = 16;
	localparam int DIV_W = 32;
	// Pin synchroniser layout and reset levels.
	localparam int PIN_W = 6;
	localparam int PIN_ESTOP_N = 0;
	localparam int PIN_SHUNT = 1;
	localparam int PIN_ZC = 2;
	localparam int PIN_PAT = 3;
	localparam logic [5:0] PIN_RST = 6'h01;
	// Fault flag positions.
	localparam int FLT_EXT_OC = 0;
	localparam int FLT_SHUNT_OC = 1;
	localparam int FLT_OV = 2;
	localparam int FLT_UV = 3;
	localparam int FLT_SPEED = 4;
	localparam int FLT_TIMEOUT = 5;
	localparam int FLT_PATTERN = 6;
	localparam int FLT_RISE_OVF = 7;
	localparam int NUM_FLT = 8;
	// System mode and startup phase codes.
	typedef enum logic [2:0] {
		SYS_INACTIVE = 3'h1,
		SYS_ACTIVE = 3'h2,
		SYS_ERROR = 3'h4
	} bdsup_sys_e;
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_ALIGN = 5'h02,
		PH_IPD = 5'h04,
		PH_OPEN = 5'h08,
		PH_CLOSED = 5'h10
	} bdsup_phase_e;
endpackage

// ---- shared/bdsup_div_if.sv ----
// Request and answer signals between the supervisor and its divider.
`timescale 1ns/100ps
interface bdsup_div_if;
	import bdsup_pkg::*;
	logic start; // One-cycle request to begin a division.
	logic [DIV_W-1:0] dividend; // May move while busy; the divider keeps its own copy.
	logic [PU_W-1:0] divisor; // May move while busy; the divider keeps its own copy.
	logic busy; // High while the divider iterates.
	logic done; // One-cycle pulse with the quotient valid.
	logic [DIV_W-1:0] quotient; // Result register.
	modport master (output start, dividend, divisor, input busy, done, quotient);
	modport slave (input start, dividend, divisor, output busy, done, quotient);
endinterface

// ---- hdl/bdsup_divider.sv ----
// Serial restoring divider used to form the modulation factor.
`timescale 1ns/100ps
module bdsup_divider (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	bdsup_div_if.slave div
);
	import bdsup_pkg::*;
	localparam int CNT_W = $clog2(DIV_W + 1);

	logic [PU_W-1:0] rem; // Partial remainder, below the divisor unless the divisor is zero.
	logic [DIV_W-1:0] quo; // Dividend shifting out, quotient shifting in.
	logic [CNT_W-1:0] cnt; // Steps left.
	logic [PU_W:0] shifted; // Remainder with the next dividend bit appended.
	logic fits; // The divisor goes into the shifted remainder.
	// Divisor captured at the start, so a bus reading that moves mid-way cannot bend one result.
	logic [PU_W-1:0] dvs;

	assign shifted = {rem, quo[DIV_W-1]};
	assign fits = shifted >= {1'b0, dvs};
	assign div.quotient = quo;

	// One quotient bit per clock; a zero divisor saturates to all ones, which
	// the caller clamps, so a dead bus never produces a wrapped small duty.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rem <= '0;
			quo <= '0;
			cnt <= '0;
			dvs <= '0;
			div.busy <= 1'b0;
			div.done <= 1'b0;
		end else begin
			div.done <= div.busy && (cnt == CNT_W'(1));
			if (div.start && !div.busy) begin
				rem <= '0;
				quo <= div.dividend;
				dvs <= div.divisor;
				cnt <= CNT_W'(DIV_W);
				div.busy <= 1'b1;
			end else if (div.busy) begin
				rem <= fits ? PU_W'(shifted - {1'b0, dvs}) : shifted[PU_W-1:0];
				quo <= {quo[DIV_W-2:0], fits};
				cnt <= cnt - CNT_W'(1);
				div.busy <= cnt != CNT_W'(1);
			end
		end
	end
endmodule

// ---- bench/bdsup_motor_model.sv ----
// Behavioural bridge and motor as seen from the supervisor's pins.
`timescale 1ns/100ps
module bdsup_motor_model
	import bdsup_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic [PAT_W-1:0] pattern_i,
	input wire logic spin_i, // Rotor turns fast enough to show crossings.
	input wire logic bad_pat_i, // Sensing returns an impossible pattern.
	input wire logic oc_ext_i, // External hardware trips on overcurrent.
	input wire logic oc_shunt_i, // Shunt comparator sees too much current.
	output logic zero_cross_o,
	output logic [PAT_W-1:0] pattern_pin_o,
	output logic hw_estop_n_o,
	output logic shunt_oc_o
);
	int cnt = 0; // Cycles within one 60 degree sector.
	// One crossing per sector; a stopped rotor gives none, as no voltage is induced.
	always @(posedge sys_clk_i) begin
		cnt <= (cnt == 59) ? 0 : cnt + 1;
		zero_cross_o <= spin_i && (cnt < 4);
	end
	// The sensed pattern follows the commutation; 0 is never legal.
	assign pattern_pin_o = bad_pat_i ? PAT_NONE : pattern_i + 3'h1;
	assign hw_estop_n_o = !oc_ext_i;
	assign shunt_oc_o = oc_shunt_i;
endmodule

// ---- bench/tb_bldc_drive_supervisor.sv ----
// Self-checking bench for the drive supervisor.
`timescale 1ns/100ps
module tb_bldc_drive_supervisor;
	import bdsup_pkg::*;
	localparam int PWM = 64; // Short carrier keeps the run brief.
	logic clk = 0, rst_n = 0, stop_e = 0, drive_e = 0, rst_e = 0, ipd_en = 0, ipd_done = 0;
	logic ovf = 0, spin = 0, bad_pat = 0, oc_ext = 0, oc_sh = 0, zc, estop_n, sh_oc;
	logic [2:0] ipd_pat = 0, pat_pin, gate_hi, gate_lo;
	logic [9:0] vbus = 10'h0c8, vcmd = 10'h064;
	logic [15:0] speed = 16'h03e8;
	bdsup_sys_e sys_mode, prev;
	bdsup_phase_e phase;
	logic [2:0] pattern;
	logic [6:0] duty;
	logic [7:0] fault;
	logic err_ev;
	logic [2:0] gate_lo_c; // Lower arms of the complementary build.
	logic [10:0] q[$]; // Expected mode and fault flags, oldest first.
	logic [31:0] seed = 32'hd13b;
	int num_errors = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	bdsup_top #(.MS_CYCLES(50), .PWM_PERIOD(PWM), .ALIGN_MS(2), .OL_STEP_MS(2),
		.TIMEOUT_MS(5), .COMPLEMENTARY(1'b0)) dut (.sys_clk_i(clk), .arst_n_i(rst_n),
		.stop_evt_i(stop_e), .drive_evt_i(drive_e), .reset_evt_i(rst_e), .ipd_en_i(ipd_en),
		.ipd_done_i(ipd_done), .ipd_pat_i(ipd_pat), .rise_cnt_ovf_i(ovf),
		.hw_estop_n_i(estop_n), .shunt_oc_i(sh_oc), .zero_cross_i(zc),
		.pattern_pin_i(pat_pin), .vbus_raw_i(vbus), .vcmd_raw_i(vcmd), .speed_rpm_i(speed),
		.sys_mode_o(sys_mode), .phase_o(phase), .pattern_o(pattern), .duty_o(duty),
		.gate_hi_o(gate_hi), .gate_lo_o(gate_lo), .fault_o(fault), .err_event_o(err_ev));
	// Second build with complementary lower arms, fed the same inputs as the first.
	bdsup_top #(.MS_CYCLES(50), .PWM_PERIOD(PWM), .ALIGN_MS(2), .OL_STEP_MS(2),
		.TIMEOUT_MS(5), .COMPLEMENTARY(1'b1)) dut_c (.sys_clk_i(clk), .arst_n_i(rst_n),
		.stop_evt_i(stop_e), .drive_evt_i(drive_e), .reset_evt_i(rst_e), .ipd_en_i(ipd_en),
		.ipd_done_i(ipd_done), .ipd_pat_i(ipd_pat), .rise_cnt_ovf_i(ovf),
		.hw_estop_n_i(estop_n), .shunt_oc_i(sh_oc), .zero_cross_i(zc),
		.pattern_pin_i(pat_pin), .vbus_raw_i(vbus), .vcmd_raw_i(vcmd), .speed_rpm_i(speed),
		.sys_mode_o(), .phase_o(), .pattern_o(), .duty_o(), .gate_hi_o(),
		.gate_lo_o(gate_lo_c), .fault_o(), .err_event_o());
	bdsup_motor_model partner (.sys_clk_i(clk), .pattern_i(pattern), .spin_i(spin),
		.bad_pat_i(bad_pat), .oc_ext_i(oc_ext), .oc_shunt_i(oc_sh), .zero_cross_o(zc),
		.pattern_pin_o(pat_pin), .hw_estop_n_o(estop_n), .shunt_oc_o(sh_oc));
	// Compares a seen value with the expected one and counts both outcomes.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// One-cycle operator or detection pulse: 0 drive, 1 stop, 2 reset, 3 done, 4 overflow.
	task automatic ev(input int k);
		@(posedge clk);
		drive_e <= (k == 0);
		stop_e <= (k == 1);
		rst_e <= (k == 2);
		ipd_done <= (k == 3);
		ovf <= (k == 4);
		@(posedge clk);
		{drive_e, stop_e, rst_e, ipd_done, ovf} <= 5'h00;
	endtask
	task automatic note(input bdsup_sys_e m, input logic [7:0] f);
		q.push_back({m, f});
	endtask
	// Waits a bounded time for a startup phase, then checks it was reached.
	task automatic wait_phase(input bdsup_phase_e p);
		int i;
		for (i = 0; i < 2000 && phase !== p; i++) @(negedge clk);
		check("phase", phase, p);
		@(posedge clk);
	endtask
	// Starts the motor; the draw-in path runs on to closed loop.
	task automatic run_up(input logic ipd);
		@(posedge clk);
		ipd_en <= ipd;
		note(SYS_ACTIVE, 8'h00);
		ev(0);
		wait_phase(ipd ? PH_IPD : PH_ALIGN);
		if (!ipd) begin
			wait_phase(PH_OPEN);
			spin <= 1'b1;
			wait_phase(PH_CLOSED);
		end
	endtask
	// Watches mode changes against the oldest note; gates must be idle unless driving.
	always @(negedge clk) begin
		logic [10:0] e;
		prev <= rst_n ? sys_mode : SYS_INACTIVE;
		if (rst_n && sys_mode !== prev) begin
			e = (q.size() > 0) ? q.pop_front() : 11'h000;
			check("sys_mode", sys_mode, e[10:8]);
			check("fault", fault, e[7:0]);
			if (sys_mode === SYS_ERROR) check("err_event", err_ev, 1'b1);
		end
		if (rst_n && sys_mode !== SYS_ACTIVE) check("gates", {gate_hi, gate_lo}, 0);
	end
	initial begin
		#(25ns * 60000);
		num_errors++;
		end_sim();
	end
	initial begin
		int r, k, nh, nl, nc, exp_d;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check("reset mode", {sys_mode, phase, pattern, duty, fault, err_ev}, {SYS_INACTIVE, PH_IDLE, 19'h0});
		ev(1);
		ev(2);
		repeat (3) @(negedge clk);
		check("refused", sys_mode, SYS_INACTIVE);
		run_up(1'b0);
		// Random command and bus voltage, both within the healthy window.
		for (r = 0; r < 4; r++) begin
			@(posedge clk);
			seed = xs(seed);
			vbus <= 10'(150 + seed % 100);
			speed <= 16'(seed % 3900);
			@(posedge clk);
			seed = xs(seed);
			vcmd <= 10'(seed % vbus);
			repeat (4 * PWM) @(negedge clk);
			exp_d = ((vcmd * VOLT_GAIN) >> GAIN_SHIFT) * PWM / ((vbus * VOLT_GAIN) >> GAIN_SHIFT);
			check("duty", duty, exp_d);
			nh = 0;
			nl = 0;
			nc = 0;
			repeat (PWM) begin
				@(negedge clk);
				nh += (gate_hi != 3'h0);
				nl += (gate_lo != 3'h0);
				nc += ($countones(gate_lo_c) == 2);
			end
			check("upper on", nh, exp_d);
			check("lower on", nl, PWM);
			check("lower comp", nc, PWM - exp_d);
		end
		note(SYS_INACTIVE, 8'h00);
		ev(1);
		spin <= 1'b0;
		run_up(1'b1);
		ipd_pat <= 3'h3;
		ev(3);
		wait_phase(PH_OPEN);
		@(negedge clk);
		check("start pattern", pattern, 3'h3);
		note(SYS_INACTIVE, 8'h00);
		ev(1);
		// Every protection path: trip, latch, clear, reset. Only the pin faults stand every
		// cycle, so only they can show a reset being refused while the fault is present.
		for (k = 0; k < NUM_FLT; k++) begin
			run_up(k == FLT_RISE_OVF);
			note(SYS_ERROR, 8'(1 << k));
			case (k)
				0: oc_ext <= 1'b1;
				1: oc_sh <= 1'b1;
				2: vbus <= 10'h12c;
				3: vbus <= 10'h064;
				4: speed <= 16'h0fa0;
				5: spin <= 1'b0;
				6: bad_pat <= 1'b1;
				default: ev(4);
			endcase
			for (r = 0; r < 1000 && sys_mode !== SYS_ERROR; r++) @(negedge clk);
			if (k < FLT_OV) ev(2);
			repeat (3) @(negedge clk);
			check("latched", sys_mode, SYS_ERROR);
			@(posedge clk);
			{oc_ext, oc_sh, spin, bad_pat, ipd_en} <= 5'h00;
			vbus <= 10'h0c8;
			speed <= 16'h03e8;
			repeat (6) @(posedge clk);
			note(SYS_INACTIVE, 8'h00);
			ev(2);
			repeat (3) @(negedge clk);
		end
		check("queue empty", q.size(), 0);
		end_sim();
	end
endmodule
